// [hdl/ssr_mem.sv]
// Synchronous 16K x 4 static RAM, memory end
`timescale 1ns/10ps
`default_nettype none
module ssr_mem #(
    parameter ssr_pkg::ssr_variant_t VARIANT = ssr_pkg::SSR_TRANSP_SEL
) (
    input  wire logic mclk,
    input  wire logic reset_n,
    ssr_if.mem        bus
);
    import ssr_pkg::*;

    // Variant decode, fixed at elaboration
    localparam bit EDGE_OUT = (VARIANT == SSR_EDGE_SEL) || (VARIANT == SSR_EDGE_OE);
    localparam bit HAS_OE   = (VARIANT == SSR_EDGE_OE) || (VARIANT == SSR_TRANSP_OE);

    logic [DATA_W-1:0] mem_array [DEPTH];
    logic [ADDR_W-1:0] cap_addr;
    logic [DATA_W-1:0] cap_data;
    logic              cap_wr;
    logic              cap_sel;
    logic              cap_rd;
    logic              sel_act;
    logic              rd_act;
    logic [DATA_W-1:0] rd_word;
    logic [DATA_W-1:0] latch_out;
    logic [DATA_W-1:0] edge_out;
    logic              latch_drive;
    logic              edge_drive;
    logic              drv;

    // Output enable versions have no select: always selected
    assign sel_act = HAS_OE ? 1'b1 : ~bus.sel_n;

    // Read request seen at the pins, and the captured cycle type
    assign rd_act = sel_act & bus.wr_en_n;
    assign cap_rd = cap_sel & ~cap_wr;

    // Input stage on one rising clock edge
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cap_addr <= ADDR_ZERO;
            cap_data <= DATA_ZERO;
            cap_wr   <= 1'b0;
            cap_sel  <= 1'b0;
        end else begin
            cap_addr <= bus.word_addr;
            cap_data <= bus.wr_data_in;
            cap_wr   <= ~bus.wr_en_n;
            cap_sel  <= sel_act;
        end
    end

    // Self-timed array write from the captured inputs, done inside the cycle
    // No external write pulse: the low phase finishes the write
    always_ff @(negedge mclk) begin
        if (cap_sel && cap_wr) begin
            mem_array[cap_addr] <= cap_data;
        end
    end

    // Array read of the address presented at the rising edge
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rd_word <= DATA_ZERO;
        end else if (rd_act) begin
            rd_word <= mem_array[bus.word_addr];
        end
    end

    // Transparent stage: opens at the fall, frozen through the high phase
    // A read shows up for the low phase and stays until the next fall
    always_ff @(negedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            latch_out <= DATA_ZERO;
        end else if (cap_rd) begin
            latch_out <= rd_word;
        end
    end

    // Transparent drive: reads drive from the fall, writes float after it
    // Held through the high phase so a write keeps driving until the fall
    always_ff @(negedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            latch_drive <= 1'b0;
        end else begin
            latch_drive <= cap_rd;
        end
    end

    // Registered stage: last cycle's read data, changes on rise only
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            edge_out <= DATA_ZERO;
        end else if (cap_rd) begin
            edge_out <= rd_word;
        end
    end

    // Registered drive: a write keeps driving until the next rise
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            edge_drive <= 1'b0;
        end else begin
            edge_drive <= cap_rd;
        end
    end

    // Output data picks the stage of this variant
    assign bus.rd_data_out = EDGE_OUT ? edge_out : latch_out;

    // Enable low while driving; output enable floats at any time
    always_comb begin
        drv = EDGE_OUT ? edge_drive : latch_drive;
        if (HAS_OE && bus.out_en_n) begin
            drv = 1'b0;
        end
        bus.rd_data_oe_n = {DATA_W{~drv}};
    end
endmodule
`default_nettype wire

// [pkg/ssr_pkg.sv]
// Package of shared constants and types for the synchronous SRAM pair
package ssr_pkg;
    localparam int ADDR_W     = 14;
    localparam int DATA_W     = 4;
    localparam int DEPTH      = 16384;
    localparam int LOW_W      = 2;
    localparam int BURST_LEN  = 4;
    localparam int FIRST_WAIT = 3;
    localparam logic [1:0] LOW_ZERO  = 2'h0;
    localparam logic [1:0] LOW_LAST  = 2'h3;
    localparam logic [1:0] WAIT_ZERO = 2'h0;
    localparam logic [1:0] WAIT_ONE  = 2'h1;
    localparam logic [3:0] DATA_ZERO = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_ZERO = 14'h0000;
    // Output stage variants and enable style
    typedef enum logic [1:0] {
        SSR_TRANSP_SEL = 2'b00,
        SSR_EDGE_SEL   = 2'b01,
        SSR_EDGE_OE    = 2'b10,
        SSR_TRANSP_OE  = 2'b11
    } ssr_variant_t;
    // Host burst sequencer states
    typedef enum logic [1:0] {
        SSR_IDLE  = 2'b00,
        SSR_FIRST = 2'b01,
        SSR_BEAT  = 2'b10
    } ssr_state_t;
endpackage

// [pkg/ssr_if.sv]
// Interface joining the memory end and the controller end
`timescale 1ns/10ps
`default_nettype none
interface ssr_if;
    logic [13:0] word_addr;
    logic [3:0]  wr_data_in;
    logic [3:0]  rd_data_out;
    logic [3:0]  rd_data_oe_n;
    logic        sel_n;
    logic        wr_en_n;
    logic        out_en_n;
    logic        counter_clk;
    modport mem (input word_addr, wr_data_in, sel_n, wr_en_n, out_en_n, counter_clk,
                 output rd_data_out, rd_data_oe_n);
    modport ctl (output word_addr, wr_data_in, sel_n, wr_en_n, out_en_n, counter_clk,
                 input rd_data_out, rd_data_oe_n);
endinterface
`default_nettype wire

// [hdl/ssr_ctl.sv]
// Cache controller end: burst fill sequencer with low address counter
`timescale 1ns/10ps
`default_nettype none
module ssr_ctl (
    input  wire logic                     mclk,
    input  wire logic                     reset_n,
    input  wire logic                     burst_request,
    input  wire logic [ssr_pkg::ADDR_W-1:0] start_addr,
    input  wire logic                     wr_req,
    input  wire logic [ssr_pkg::DATA_W-1:0] wr_word,
    output logic                          burst_acknowledge,
    output logic                          beat_valid,
    output logic [ssr_pkg::DATA_W-1:0]    beat_data,
    output logic                          counter_load,
    ssr_if.ctl                            bus
);
    import ssr_pkg::*;

    ssr_state_t       state;
    logic [LOW_W-1:0] low_cnt;
    logic [1:0]       wait_cnt;
    logic [1:0]       beats;

    // Single clock, opposite phase, put on the bus; neither the low counter nor the memory end uses it
    assign bus.counter_clk = ~mclk;
    assign bus.out_en_n    = 1'b0;

    // Burst sequencer, first word after three cycles then one each
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state             <= SSR_IDLE;
            burst_acknowledge <= 1'b0;
            counter_load      <= 1'b0;
            wait_cnt          <= WAIT_ZERO;
            beats             <= LOW_ZERO;
            beat_valid        <= 1'b0;
            beat_data         <= DATA_ZERO;
        end else begin
            beat_valid   <= 1'b0;
            counter_load <= 1'b0;
            unique case (state)
                SSR_IDLE: begin
                    if (burst_request) begin
                        burst_acknowledge <= 1'b1;
                        counter_load      <= 1'b1;
                        wait_cnt          <= 2'(FIRST_WAIT - 1);
                        beats             <= LOW_ZERO;
                        state             <= SSR_FIRST;
                    end
                end
                SSR_FIRST: begin
                    wait_cnt <= wait_cnt - WAIT_ONE;
                    if (wait_cnt == WAIT_ONE) begin
                        state <= SSR_BEAT;
                    end
                end
                SSR_BEAT: begin
                    beat_valid <= 1'b1;
                    beat_data  <= bus.rd_data_out;
                    beats      <= beats + WAIT_ONE;
                    if (beats == LOW_LAST) begin
                        burst_acknowledge <= 1'b0;
                        state             <= SSR_IDLE;
                    end
                end
                default: state <= SSR_IDLE;
            endcase
        end
    end

    // Low address counter: load at start, count each cycle of SSR_FIRST and SSR_BEAT
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            low_cnt <= LOW_ZERO;
        end else if (state == SSR_IDLE && burst_request) begin
            low_cnt <= start_addr[LOW_W-1:0];
        end else if (state == SSR_FIRST || state == SSR_BEAT) begin
            low_cnt <= low_cnt + WAIT_ONE;
        end
    end

    // Address and control to the memory
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            bus.word_addr  <= ADDR_ZERO;
            bus.wr_data_in <= DATA_ZERO;
            bus.sel_n      <= 1'b1;
            bus.wr_en_n    <= 1'b1;
        end else begin
            // Idle: single access at the full start address
            if (state == SSR_IDLE) begin
                bus.word_addr <= start_addr;
            end else begin
                bus.word_addr <= {start_addr[ADDR_W-1:LOW_W], low_cnt};
            end
            bus.wr_data_in <= wr_word;
            bus.sel_n      <= ~((state != SSR_IDLE) || (wr_req && !burst_request));
            bus.wr_en_n    <= ~(state == SSR_IDLE && wr_req && !burst_request);
        end
    end
endmodule
`default_nettype wire

// [verification/ssr_chk_sva.sv]
// Assertion checker watching the memory interface signals
`timescale 1ns/10ps
`default_nettype none
module ssr_chk (
    input wire logic        mclk,
    input wire logic        reset_n,
    input wire logic [13:0] word_addr,
    input wire logic [3:0]  rd_data_out,
    input wire logic [3:0]  rd_data_oe_n,
    input wire logic        sel_n,
    input wire logic        wr_en_n,
    input wire logic        counter_clk
);
    logic [3:0] hi_val;
    // Output value held across the high phase
    always_ff @(posedge mclk) begin
        hi_val <= rd_data_out;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    AST_CLK_INV: assert property (counter_clk == 1'b1)
        else $error("counter clock not opposite phase");
    AST_HOLD_LOW: assert property (@(negedge mclk) rd_data_out == hi_val)
        else $error("data output changed while clock high");
    AST_RD_DRIVE: assert property ($past(!sel_n && wr_en_n) |-> rd_data_oe_n == 4'h0)
        else $error("read data not driven in clock low");
    AST_WR_FLOAT: assert property ($past(!sel_n && !wr_en_n) |-> rd_data_oe_n == 4'hF)
        else $error("outputs not floated after write");
    AST_DESEL_KEEP: assert property ($past(sel_n) |-> $stable(rd_data_out))
        else $error("output changed in deselected cycle");
    AST_OE_UNIFORM: assert property (rd_data_oe_n == 4'h0 || rd_data_oe_n == 4'hF)
        else $error("output enables split");
    AST_UPPER_HELD: assert property (!sel_n ##1 !sel_n |-> $stable(word_addr[13:2]))
        else $error("upper address moved within access run");
    AST_LOW_STEP: assert property (!sel_n && wr_en_n ##1 !sel_n && wr_en_n |->
        word_addr[1:0] inside {$past(word_addr[1:0]), $past(word_addr[1:0]) + 2'h1})
        else $error("low address not counting");
    COV_READ: cover property (!sel_n && wr_en_n ##1 !sel_n && wr_en_n);
    COV_WRITE: cover property (!sel_n && !wr_en_n);
    COV_STEP: cover property (!sel_n ##1 word_addr[1:0] != $past(word_addr[1:0]));
endmodule
`default_nettype wire

// [verification/tb_top.sv]
// Self-checking bench joining memory end and controller end
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import ssr_pkg::*;
    logic              mclk = 1'b0;
    logic              reset_n = 1'b0;
    logic              burst_request = 1'b0;
    logic [ADDR_W-1:0] start_addr = ADDR_ZERO;
    logic [ADDR_W-1:0] base;
    logic              wr_req = 1'b0;
    logic [DATA_W-1:0] wr_word = DATA_ZERO;
    logic              burst_acknowledge;
    logic              beat_valid;
    logic [DATA_W-1:0] beat_data;
    logic              counter_load;
    logic [31:0]       seed = 32'h0001_2C23;
    logic [DATA_W-1:0] exp_q[$];
    logic [DATA_W-1:0] blk[4];
    logic              prev_beat = 1'b0;
    int                miscompares = 0;
    int                n_tests = 0;
    int                beat_idx = 0;
    ssr_if sif ();
    ssr_mem #(.VARIANT(SSR_TRANSP_SEL)) ssr_mem_inst (.mclk(mclk), .reset_n(reset_n), .bus(sif));
    ssr_ctl ssr_ctl_inst (.mclk(mclk), .reset_n(reset_n), .burst_request(burst_request),
        .start_addr(start_addr), .wr_req(wr_req), .wr_word(wr_word),
        .burst_acknowledge(burst_acknowledge), .beat_valid(beat_valid),
        .beat_data(beat_data), .counter_load(counter_load), .bus(sif));
    ssr_chk ssr_chk_inst (.mclk(mclk), .reset_n(reset_n), .word_addr(sif.word_addr),
        .rd_data_out(sif.rd_data_out), .rd_data_oe_n(sif.rd_data_oe_n), .sel_n(sif.sel_n),
        .wr_en_n(sif.wr_en_n), .counter_clk(sif.counter_clk));
    // Clock of 10 ns period
    always #5 mclk = ~mclk;
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        $display("Compares %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Single write from idle, then let it settle
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        start_addr <= a;
        wr_word <= d;
        wr_req <= 1'b1;
        @(posedge mclk);
        wr_req <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask
    // Burst fill: note wrapped expectations, request, await acknowledge
    task automatic burst(input logic [ADDR_W-1:0] a);
        int k;
        beat_idx = 0;
        for (k = 0; k < BURST_LEN; k++) exp_q.push_back(blk[2'(a[1:0] + k)]);
        start_addr <= a;
        burst_request <= 1'b1;
        k = 0;
        do begin @(posedge mclk); k++; end while (burst_acknowledge !== 1'b1 && k < 4);
        check(k <= 2, 1);
        check(counter_load, 1);
        burst_request <= 1'b0;
        k = 0;
        while (burst_acknowledge !== 1'b0 && k < 20) begin @(posedge mclk); k++; end
        @(posedge mclk);
        check(beat_idx, BURST_LEN);
        check(exp_q.size(), 0);
    endtask
    // Compare each beat against the oldest note
    always @(posedge mclk) begin
        if (beat_valid === 1'b1) begin
            if (beat_idx > 0) check(prev_beat, 1);
            if (exp_q.size() == 0) check(1, 0);
            else check(beat_data, exp_q.pop_front());
            beat_idx++;
        end
        prev_beat <= beat_valid;
    end
    // Cut a hang short
    initial begin
        #50_000;
        miscompares++;
        test_done();
    end
    // Main sequence: random blocks written then burst back from random offsets
    initial begin
        repeat (10) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
        for (int n = 0; n < 6; n++) begin
            seed = xs(seed);
            base = seed[ADDR_W-1:0];
            for (int k = 0; k < 4; k++) begin
                seed = xs(seed);
                blk[k] = seed[DATA_W-1:0];
                wr({base[13:2], 2'(k)}, blk[k]);
            end
            burst(base);
        end
        test_done();
    end
endmodule
`default_nettype wire
